// ---- hdl/liu_line_control_los_monitor.sv ----
// Contract
// [R1] Sync-clock select makes the transmitter send a square-wave clock.
// [R2] Host centres the sync pulse by writing two analog trim locations; this block maps none, so such writes get pslverr.
// [R3] Power-down releases both transmit pins to high impedance.
// [R4] Alarm request sends continuous ones on master timing, ignoring framer.
// [R5] Auto-alarm with receive loss also sends all ones.
// [R6] Real-time status bit 2 shows the short-circuit limiter, unlatched.
// [R7] Latched faults raise the interrupt only when their mask bit is set.
// [R8] Real-time status bit 1 shows an open transmit output, unlatched.
// [R9] Open-circuit reporting is off for build-out settings 5, 6, 7.
// [R10] Termination switch comes out of reset open, high impedance.
// [R11] Termination bits decode to four internal/external combinations.
// [R12] Host programs receive impedance to match the line.
// [R13] Two-bit sensitivity field sets the loss thresholds.
// [R14] Clock recovery oversamples the received signal sixteen times.
// [R15] Receive clock output is the recovered line clock.
// [R16] During carrier loss the receive clock comes from the master clock.
// [R17] Signal level is reported as a four-bit code.
// [R18] Receive control bit 7 accepts a square-wave sync clock.
// [R19] Loss declares 3dB below sensitivity, exits at sensitivity: hysteresis.
// [R20] T1 loss after 175 empty bits; clears on ones density window.
// [R21] G.775 loss after empty bits; clears after persistent transitions.
// [R22] ETS loss after 2048 empty bits; no own reset condition.
// [R23] E1 loss resets after 192 bits at or above sensitivity.
// [R24] Latched bits set on rising condition, held until host clears.
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`include "liu_line_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module liu_line_control_los_monitor
  import liu_line_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [17:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        oversample_tick,
  input  wire logic        tx_data,
  input  wire logic        tx_short_circuit_now,
  input  wire logic        tx_open_circuit_now,
  input  wire logic [3:0]  rx_level_code,
  input  wire logic        rx_line_pos,
  input  wire logic        rx_line_neg,
  output logic             tx_line_pos,
  output logic             tx_line_pos_oe,
  output logic             tx_line_neg,
  output logic             tx_line_neg_oe,
  output logic             rx_internal_term_on,
  output logic             rx_external_pin_connect,
  output logic [1:0]       rx_impedance_sel,
  output logic             recovered_clock_out,
  output logic             rx_data,
  output logic             rx_carrier_loss,
  output logic             line_irq
);

  ////////////////////////////////////////////////////////////////////////////
  state_s s_q, s_d;
  logic [15:0] idx;
  logic        setup, access, hit, w_en;
  logic [2:0]  rt_now;
  logic [3:0]  sens_thr;
  logic        lvl_ok, lvl_weak, mark_now, bit_end, alarm, e1, ets;
  logic        open_ok;
  cnt_t        zero_lim;
  reg8_t       rd_val;

  // Word addressing: the low two address bits are ignored by decode.
  assign idx    = paddr[17:2];
  assign setup  = psel && !penable;
  assign access = psel && penable;
  assign pready = 1'b1;
  assign w_en   = access && pwrite && hit;

  // Read mux; also flags which indexes are mapped.
  always_comb begin
    hit    = 1'b1;
    rd_val = 8'h00;
    unique case (idx)
      `IDX_LINE_CTRL: rd_val = s_q.line_ctrl;
      `IDX_TX_SHAPE:  rd_val = s_q.tx_shape;
      `IDX_MAINT:     rd_val = s_q.maint;
      `IDX_RT_STATUS: rd_val = {5'h00, rt_now};
      `IDX_IRQ_MASK:  rd_val = s_q.irq_mask;
      `IDX_LATCHED:   rd_val = s_q.latched;
      `IDX_RX_LEVEL:  rd_val = {4'h0, s_q.lvl};                  // [R17]
      `IDX_RX_TERM:   rd_val = s_q.rx_term;
      `IDX_RX_CTRL:   rd_val = s_q.rx_ctrl;
      default:        hit = 1'b0;
    endcase
  end

  assign pslverr = access && !hit;

  ////////////////////////////////////////////////////////////////////////////
  // Open detection is meaningless on CSU build-outs, so it is masked there.
  assign open_ok = s_q.tx_shape[`TS_LBO_LSB +: 3] < 3'h5;          // [R9]
  assign rt_now  = {s_q.shrt,                                      // [R6]
                    s_q.open && open_ok,                           // [R8]
                    s_q.loss};

  // Sensitivity maps to the weakest acceptable level code; one more step
  // (about 2.5dB, nearest to 3dB) is the loss declaration level.
  always_comb begin
    unique case (s_q.rx_ctrl[`RC_SENS_LSB +: 2])                   // [R13]
      2'h0:    sens_thr = 4'h5;
      2'h1:    sens_thr = 4'h7;
      2'h2:    sens_thr = 4'hC;
      default: sens_thr = 4'hE;
    endcase
  end

  assign lvl_ok   = s_q.lvl <= sens_thr;                           // [R19]
  assign lvl_weak = s_q.lvl > sens_thr + 4'h1;                     // [R19]
  assign mark_now = s_q.pos_s[2] || s_q.neg_s[2];
  assign bit_end  = oversample_tick && (s_q.mph == 4'hF);
  assign e1       = s_q.line_ctrl[`LC_E1_BIT];
  assign ets      = s_q.line_ctrl[`LC_ETS_BIT];
  assign alarm    = s_q.maint[`MC_ALARM_BIT] ||                    // [R4]
                    (s_q.maint[`MC_AUTO_BIT] && s_q.loss);         // [R5]
  assign zero_lim = s_q.line_ctrl[`LC_B8ZS_BIT] ? `T1_ZEROS_B8ZS
                                                 : `T1_ZEROS_AMI;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic for the whole block.
  always_comb begin
    s_d = s_q;
    // Pin synchronisers: fault and level values are taken once stages two and three agree; line pins are used from stage three.
    s_d.pos_s  = {s_q.pos_s[1:0], rx_line_pos};
    s_d.neg_s  = {s_q.neg_s[1:0], rx_line_neg};
    s_d.shrt_s = {s_q.shrt_s[1:0], tx_short_circuit_now};
    s_d.open_s = {s_q.open_s[1:0], tx_open_circuit_now};
    s_d.lvl_s  = {s_q.lvl_s[7:0], rx_level_code};
    if (s_q.shrt_s[2] == s_q.shrt_s[1]) begin
      s_d.shrt = s_q.shrt_s[2];
    end
    if (s_q.open_s[2] == s_q.open_s[1]) begin
      s_d.open = s_q.open_s[2];
    end
    if (s_q.lvl_s[11:8] == s_q.lvl_s[7:4]) begin
      s_d.lvl = s_q.lvl_s[11:8];
    end

    // Register writes.
    if (w_en) begin
      unique case (idx)
        `IDX_LINE_CTRL: s_d.line_ctrl = pwdata[7:0];
        `IDX_TX_SHAPE:  s_d.tx_shape  = pwdata[7:0];
        `IDX_MAINT:     s_d.maint     = pwdata[7:0];
        `IDX_IRQ_MASK:  s_d.irq_mask  = pwdata[7:0];
        `IDX_LATCHED:   s_d.latched   = s_q.latched & ~pwdata[7:0];
        `IDX_RX_TERM:   s_d.rx_term   = pwdata[7:0];
        `IDX_RX_CTRL:   s_d.rx_ctrl   = pwdata[7:0];
        default:        s_d.latched   = s_q.latched;
      endcase
    end
    // Latching after the clear so that a new edge wins over the clear.
    s_d.rt_prev = rt_now;
    s_d.latched = {s_d.latched[7:3],
                   s_d.latched[2:0] | (rt_now & ~s_q.rt_prev)};     // [R24]

    // Read data is captured in the setup cycle and shown in the access one.
    if (setup) begin
      s_d.prdata = {24'h000000, rd_val};
    end

    // Master-timed bit phase, sixteen ticks per bit.
    if (oversample_tick) begin
      s_d.mph = s_q.mph + 4'h1;                                    // [R14]
    end

    // Recovery: re-phase to a fresh mark, decide at mid-bit.
    if (oversample_tick) begin
      s_d.rx_mark_prev = mark_now;
      if (mark_now && !s_q.rx_mark_prev) begin
        s_d.rph       = 4'h0;                                      // [R14]
        s_d.mark_seen = 1'b1;
      end else begin
        s_d.rph = s_q.rph + 4'h1;
      end
      if (s_q.rph == `OVS_MID) begin
        s_d.rx_data   = s_q.mark_seen && !s_q.rx_ctrl[`RC_SYNC_BIT];
        s_d.mark_seen = 1'b0;
      end
    end

    // A pulse counts for loss purposes only at a usable level.
    if (mark_now && !lvl_weak) begin
      s_d.pulse_bit = 1'b1;
    end

    // Transmit encoder, stepping on master bit boundaries.
    if (bit_end) begin
      if (alarm || tx_data) begin
        s_d.ami_pol = !s_q.ami_pol;
        s_d.txp     = !s_q.ami_pol;
        s_d.txn     = s_q.ami_pol;
      end else begin
        s_d.txp = 1'b0;
        s_d.txn = 1'b0;
      end
    end

    // Loss detection, one step per bit period.
    if (bit_end) begin
      s_d.pulse_bit = 1'b0;
      s_d.zero_run  = s_q.pulse_bit ? 12'd0
                    : (s_q.zero_run == 12'hFFF ? s_q.zero_run
                                               : s_q.zero_run + 12'd1);
      s_d.good_run  = lvl_ok ? s_q.good_run + 12'd1 : 12'd0;
      if (!s_q.loss) begin
        s_d.win_cnt  = 12'd0;
        s_d.ones_cnt = 12'd0;
        s_d.win_bad  = 1'b0;
        s_d.good_run = 12'd0;
        if (!e1 && s_q.zero_run >= `T1_WINDOW) begin
          s_d.loss = 1'b1;                                         // [R20]
        end
        if (e1 && !ets && s_q.zero_run >= `G775_DECLARE) begin
          s_d.loss = 1'b1;                                         // [R21]
        end
        if (e1 && ets && s_q.zero_run >= `ETS_DECLARE) begin
          s_d.loss = 1'b1;                                         // [R22]
        end
      end else if (!e1) begin
        // T1 reset: density over a window with no long zero run.
        s_d.win_cnt  = s_q.win_cnt + 12'd1;
        s_d.ones_cnt = s_q.ones_cnt + {11'd0, s_q.pulse_bit && lvl_ok};
        if (s_q.zero_run >= zero_lim) begin
          s_d.win_bad = 1'b1;                                      // [R20]
        end
        if (s_q.win_cnt == `T1_WINDOW - 12'd1) begin
          if (!s_d.win_bad && s_d.ones_cnt >= `T1_MIN_ONES) begin
            s_d.loss = 1'b0;                                       // [R20]
          end
          s_d.win_cnt  = 12'd0;
          s_d.ones_cnt = 12'd0;
          s_d.win_bad  = 1'b0;
        end
      end else begin
        // E1 reset: level held at sensitivity; G.775 also needs pulses.
        if (!ets && s_q.zero_run >= `G775_DECLARE) begin
          s_d.good_run = 12'd0;                                    // [R21]
        end
        if (s_d.good_run >= `E1_RESET_BITS) begin
          s_d.loss = 1'b0;                                         // [R23]
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; termination switch resets open.
  always_ff @(posedge clk) begin
    if (reset) begin
      s_q         <= '0;
      s_q.rx_term <= `RST_CTRL;                                    // [R10]
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit pins: sync clock replaces data; power-down floats both pins.
  always_comb begin
    if (s_q.tx_shape[`TS_SYNC_BIT]) begin
      tx_line_pos = s_q.mph < `OVS_HALF;                           // [R1]
      tx_line_neg = s_q.mph >= `OVS_HALF;                          // [R1]
    end else begin
      tx_line_pos = s_q.txp;
      tx_line_neg = s_q.txn;
    end
    tx_line_pos_oe = !s_q.maint[`MC_PDN_BIT];                      // [R3]
    tx_line_neg_oe = !s_q.maint[`MC_PDN_BIT];                      // [R3]
  end

  // Receive clock: recovered phase normally, master phase during loss,
  // and the incoming square wave itself in sync-clock mode.
  always_comb begin
    if (s_q.rx_ctrl[`RC_SYNC_BIT]) begin
      recovered_clock_out = s_q.pos_s[2];                          // [R18]
    end else if (s_q.loss) begin
      recovered_clock_out = s_q.mph < `OVS_HALF;                   // [R16]
    end else begin
      recovered_clock_out = s_q.rph < `OVS_HALF;                   // [R15]
    end
  end

  assign rx_internal_term_on     = s_q.rx_term[`RT_INT_BIT];      // [R11]
  assign rx_external_pin_connect = s_q.rx_term[`RT_EXT_BIT];      // [R11]
  assign rx_impedance_sel        = s_q.rx_term[`RT_IMP_LSB +: 2];
  assign rx_data                 = s_q.rx_data;
  assign rx_carrier_loss         = s_q.loss;
  assign prdata                  = s_q.prdata;
  assign line_irq = |(s_q.latched[2:0] & s_q.irq_mask[2:0]);       // [R7]

endmodule
`default_nettype wire

// ---- hdl/liu_line_regs.svh ----
`ifndef LIU_LINE_REGS_SVH
`define LIU_LINE_REGS_SVH
// Register indexes; the byte address on the bus is four times the index.
`define IDX_LINE_CTRL      16'h1000
`define IDX_TX_SHAPE       16'h1001
`define IDX_MAINT          16'h1002
`define IDX_RT_STATUS      16'h1003
`define IDX_IRQ_MASK       16'h1004
`define IDX_LATCHED        16'h1005
`define IDX_RX_LEVEL       16'h1006
`define IDX_RX_TERM        16'h1007
`define IDX_RX_CTRL        16'h1008
// Line control fields.
`define LC_E1_BIT          0
`define LC_ETS_BIT         1
`define LC_B8ZS_BIT        2
// Transmit shape fields.
`define TS_LBO_LSB         0
`define TS_SYNC_BIT        3
// Maintenance fields.
`define MC_PDN_BIT         0
`define MC_ALARM_BIT       1
`define MC_AUTO_BIT        2
// Status fields, shared by real-time, latched and mask registers.
`define ST_LOSS_BIT        0
`define ST_OPEN_BIT        1
`define ST_SHORT_BIT       2
// Receive termination fields.
`define RT_IMP_LSB         0
`define RT_EXT_BIT         2
`define RT_INT_BIT         3
// Receive control fields.
`define RC_SENS_LSB        0
`define RC_SYNC_BIT        7
// Reset values.
`define RST_CTRL           8'h00
// Loss timing in bit periods; oversample phase points in ticks.
`define T1_WINDOW          12'd175
`define T1_MIN_ONES        12'd22
`define T1_ZEROS_B8ZS      12'd8
`define T1_ZEROS_AMI       12'd100
`define G775_DECLARE       12'd32
`define ETS_DECLARE        12'd2048
`define E1_RESET_BITS      12'd192
`define OVS_MID            4'h7
`define OVS_HALF           4'h8
`endif

// ---- hdl/liu_line_pkg.sv ----
package liu_line_pkg;
  typedef logic [7:0] reg8_t;
  typedef logic [11:0] cnt_t;
  typedef struct packed {
    reg8_t      line_ctrl;
    reg8_t      tx_shape;
    reg8_t      maint;
    reg8_t      irq_mask;
    reg8_t      latched;
    reg8_t      rx_term;
    reg8_t      rx_ctrl;
    logic [2:0] rt_prev;
    logic [31:0] prdata;
    logic [2:0] pos_s, neg_s, shrt_s, open_s;
    logic [11:0] lvl_s;
    logic       shrt, open;
    logic [3:0] lvl;
    logic [3:0] mph, rph;
    logic       rx_mark_prev, mark_seen, pulse_bit;
    logic       rx_data, ami_pol, txp, txn;
    logic       loss;
    cnt_t       zero_run, win_cnt, ones_cnt, good_run;
    logic       win_bad;
  } state_s;
endpackage

// ---- testbench/liu_line_props.sv ----
`timescale 1ns/100ps
`default_nettype none
module liu_line_props (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        tx_short_circuit_now,
  input wire logic        tx_open_circuit_now,
  input wire logic        tx_line_pos,
  input wire logic        tx_line_neg,
  input wire logic        tx_line_pos_oe,
  input wire logic        tx_line_neg_oe,
  input wire logic        rx_internal_term_on,
  input wire logic        rx_external_pin_connect,
  input wire logic [1:0]  rx_impedance_sel,
  input wire logic        line_irq
);
  logic       wr_c, rd_rt;
  logic [1:0] prev_q;
  logic [3:0] stab_q;
  logic [2:0] lbo_q;
  // Decode of the bus cycles that the properties care about.
  assign wr_c = psel && penable && pwrite;
  assign rd_rt = psel && penable && !pwrite && paddr == 18'h0400C;
  // Fault inputs pass synchronisers, so status is judged only once they
  // have held still; build-out is shadowed to know when open is masked.
  always_ff @(posedge clk) begin
    prev_q <= {tx_short_circuit_now, tx_open_circuit_now};
    if (reset || prev_q != {tx_short_circuit_now, tx_open_circuit_now})
      stab_q <= 4'h0;
    else if (stab_q != 4'hF)
      stab_q <= stab_q + 4'h1;
    if (reset)
      lbo_q <= 3'h0;
    else if (wr_c && paddr == 18'h04004)
      lbo_q <= pwdata[2:0];
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_pdn_oe: assert property (wr_c && paddr == 18'h04008 |=>
    tx_line_pos_oe == !$past(pwdata[0])) else $error("Pin drive wrong.");
  a_oe_pair: assert property (tx_line_pos_oe == tx_line_neg_oe)
    else $error("Pin drives disagree.");
  a_term_rst: assert property ($fell(reset) |->
    !rx_internal_term_on && !rx_external_pin_connect)
    else $error("Termination not open after reset.");
  a_term_dec: assert property (wr_c && paddr == 18'h0401C |=>
    {rx_internal_term_on, rx_external_pin_connect, rx_impedance_sel}
    == $past(pwdata[3:0])) else $error("Termination decode wrong.");
  a_mask_off: assert property (wr_c && paddr == 18'h04010 &&
    pwdata[2:0] == 3'h0 |=> !line_irq) else $error("Masked irq raised.");
  a_short_rt: assert property (rd_rt && stab_q >= 4'h8 |->
    prdata[2] == tx_short_circuit_now) else $error("Short status wrong.");
  a_open_rt: assert property (rd_rt && stab_q >= 4'h8 |->
    prdata[1] == (tx_open_circuit_now && lbo_q < 3'h5))
    else $error("Open status wrong.");
  a_alarm_tx: assert property (wr_c && paddr == 18'h04008 &&
    pwdata[1:0] == 2'b10 |-> ##[1:40] (tx_line_pos || tx_line_neg))
    else $error("No alarm marks sent.");
endmodule
`default_nettype wire

// ---- testbench/line_far_end.sv ----
`timescale 1ns/100ps
`default_nettype none
module line_far_end (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       sig_on,
  input  wire logic [3:0] line_level,
  output logic            rx_line_pos,
  output logic            rx_line_neg,
  output logic [3:0]      rx_level_code
);
  logic [3:0] ph_q;
  logic       pol_q;
  // Half-bit AMI marks every 16 cycles; a dead line shows no marks and
  // the weakest level code, as a real cut cable would.
  always_ff @(posedge clk) begin
    ph_q <= reset ? 4'h0 : ph_q + 4'h1;
    if (reset)
      pol_q <= 1'b0;
    else if (ph_q == 4'hF)
      pol_q <= ~pol_q;
    rx_line_pos <= sig_on && ph_q < 4'h8 && pol_q;
    rx_line_neg <= sig_on && ph_q < 4'h8 && !pol_q;
    rx_level_code <= sig_on ? line_level : 4'hF;
  end
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        clk, reset, psel, penable, pwrite, pready, pslverr, perr;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        tx_data, tx_short_circuit_now, tx_open_circuit_now;
  logic        rx_line_pos, rx_line_neg, sig_on, sp, sn;
  logic [3:0]  rx_level_code, line_level;
  logic        tx_line_pos, tx_line_pos_oe, tx_line_neg, tx_line_neg_oe;
  logic        rx_internal_term_on, rx_external_pin_connect, rx_data;
  logic [1:0]  rx_impedance_sel;
  logic        recovered_clock_out, rx_carrier_loss, line_irq;
  int          mismatches, cmp_count, n;
  int          cyc = 0;
  // Tick every cycle, so one bit period is 16 cycles.
  liu_line_control_los_monitor u_dut (.*, .oversample_tick(1'b1));
  line_far_end u_line (.*);
  // Clock of 100 ns period.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // The run needs about 60000 cycles; a hang stops well after that.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      mismatches++;
      wrap_up();
    end
  end
  task wrap_up;
    $display("compares=%0d mismatches=%0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One bus transfer; settles to the falling edge so callers may sample.
  task apb(input logic w, input logic [17:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge clk);
  endtask
  task wr(input logic [17:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [17:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  task line(input logic on, input logic [3:0] lvl);
    @(posedge clk);
    sig_on <= on;
    line_level <= lvl;
  endtask
  task wait_loss(input logic v, input int lo, input int hi);
    n = 0;
    while (rx_carrier_loss !== v && n < hi) begin
      @(negedge clk);
      n++;
    end
    chk(32'({rx_carrier_loss, n >= lo}), 32'({v, 1'b1}));
  endtask
  task marks;
    sp = 1'b0;
    sn = 1'b0;
    repeat (32) @(negedge clk);
    repeat (64) begin
      @(negedge clk);
      sp = sp | (tx_line_pos === 1'b1);
      sn = sn | (tx_line_neg === 1'b1);
    end
  endtask
  task t_reset;
    @(negedge clk);
    chk({rx_internal_term_on, rx_external_pin_connect, rx_impedance_sel,
      tx_line_pos_oe, tx_line_neg_oe, rx_carrier_loss, line_irq}, 8'h0C);
    rd(18'h0401C, 32'h0);
    rd(18'h04018, 32'h2);
    apb(1'b0, 18'h04024, 32'h0);
    chk(rdat | {perr, 31'h0}, 32'h80000000);
    $display("reset test done");
  endtask
  task t_term;
    for (int i = 0; i < 16; i++) begin
      wr(18'h0401C, i);
      chk({rx_internal_term_on, rx_external_pin_connect,
        rx_impedance_sel}, i);
    end
    chk(rx_data, 32'h1);
    // Sync-clock receive: clock follows the line, data is held low.
    wr(18'h04020, 32'h80);
    n = 0;
    sp = recovered_clock_out;
    repeat (64) begin
      @(negedge clk);
      n += 32'(recovered_clock_out !== sp);
      sp = recovered_clock_out;
    end
    chk(32'({n >= 2, rx_data}), 32'h2);
    wr(18'h04020, 32'h0);
    wr(18'h04008, 32'h1);
    chk({tx_line_pos_oe, tx_line_neg_oe}, 32'h0);
    wr(18'h04008, 32'h0);
    chk({tx_line_pos_oe, tx_line_neg_oe}, 32'h3);
    $display("termination and power test done");
  endtask
  task t_status;
    @(posedge clk);
    tx_short_circuit_now <= 1'b1;
    tx_open_circuit_now <= 1'b1;
    repeat (8) @(posedge clk);
    rd(18'h0400C, 32'h6);
    rd(18'h04014, 32'h6);
    chk(line_irq, 32'h0);
    wr(18'h04010, 32'h4);
    chk(line_irq, 32'h1);
    wr(18'h04004, 32'h5);
    rd(18'h0400C, 32'h4);
    tx_short_circuit_now <= 1'b0;
    tx_open_circuit_now <= 1'b0;
    repeat (8) @(posedge clk);
    rd(18'h04014, 32'h6);
    wr(18'h04014, 32'h6);
    rd(18'h04014, 32'h0);
    chk(line_irq, 32'h0);
    wr(18'h04010, 32'h0);
    chk(line_irq, 32'h0);
    wr(18'h04004, 32'h8);
    // Pulse centring trim lives outside this block; the write is refused.
    apb(1'b1, 18'h048A4, 32'hF8);
    chk(perr, 32'h1);
    marks();
    chk(sp, 32'h1);
    wr(18'h04004, 32'h0);
    wr(18'h04008, 32'h2);
    marks();
    chk({sp, sn}, 32'h3);
    wr(18'h04008, 32'h0);
    marks();
    chk({sp, sn}, 32'h0);
    $display("status and transmit test done");
  endtask
  task t_t1;
    line(1'b0, 4'h2);
    wait_loss(1'b1, 175 * 16, 178 * 16);
    n = 0;
    sp = recovered_clock_out;
    repeat (32) begin
      @(negedge clk);
      n += 32'(recovered_clock_out !== sp);
      sp = recovered_clock_out;
    end
    chk(n, 32'h4);
    rd(18'h04014, 32'h1);
    wr(18'h04008, 32'h4);
    marks();
    chk({sp, sn}, 32'h3);
    wr(18'h04008, 32'h0);
    line(1'b1, 4'h2);
    wait_loss(1'b0, 1, 360 * 16);
    wr(18'h04014, 32'h1);
    $display("T1 loss test done");
  endtask
  task t_e1;
    wr(18'h04000, 32'h1);
    line(1'b0, 4'h2);
    wait_loss(1'b1, 31 * 16, 35 * 16);
    line(1'b1, 4'h6);
    repeat (300 * 16) @(negedge clk);
    chk(rx_carrier_loss, 32'h1);
    line(1'b1, 4'h2);
    wait_loss(1'b0, 190 * 16, 194 * 16);
    line(1'b1, 4'h6);
    repeat (300 * 16) @(negedge clk);
    chk(rx_carrier_loss, 32'h0);
    wr(18'h04000, 32'h3);
    line(1'b0, 4'h2);
    wait_loss(1'b1, 2047 * 16, 2051 * 16);
    line(1'b1, 4'h2);
    wait_loss(1'b0, 190 * 16, 194 * 16);
    $display("E1 loss test done");
  endtask
  // Main sequence: reset for five cycles, then each scenario in turn.
  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 18'h0;
    pwdata = 32'h0;
    tx_data = 1'b0;
    tx_short_circuit_now = 1'b0;
    tx_open_circuit_now = 1'b0;
    sig_on = 1'b1;
    line_level = 4'h2;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_term();
    t_status();
    t_t1();
    t_e1();
    wrap_up();
  end
endmodule
bind liu_line_control_los_monitor liu_line_props u_props (.*);
`default_nettype wire
